// file: dlcr_chan_mem.sv
// four-entry channel register store with registered read data
module dlcr_chan_mem
  import dlcr_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        wr_en,
  input  wire logic [1:0]  wr_addr,
  input  wire logic [15:0] wr_data,
  input  wire logic [1:0]  rd_addr,
  output logic      [15:0] rd_data
);
  `include "dlcr_regs.svh"

  logic [15:0] mem [0:`DLCR_CHAN_COUNT-1];

  always_ff @(posedge MCLK) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge MCLK) begin
    rd_data <= mem[rd_addr];
  end
endmodule // dlcr_chan_mem

// file: dlcr_host.sv
// host model driving the three-wire link
module dlcr_host
  import dlcr_pkg::*;
(
  output logic      SCLK,
  output logic      FRAME_N,
  output logic      SERIAL_IN,
  input  wire logic SERIAL_OUT
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    SCLK = 1'b0;
    FRAME_N = 1'b1;
    SERIAL_IN = 1'b0;
  end
  // one framed word, msb first; clock stands low outside frames
  task automatic xfer(input logic [23:0] w, output logic [23:0] r);
    #62.5 FRAME_N = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      #62.5 SCLK = 1'b1;
      SERIAL_IN = w[i];
      #62.5 SCLK = 1'b0;
      r[i] = SERIAL_OUT;
    end
    #62.5 FRAME_N = 1'b1;
    SERIAL_IN = ~SERIAL_IN;
  endtask
endmodule // dlcr_host

// file: dlcr_pkg.sv
// types shared by the quad dac load, clear and readout block
package dlcr_pkg;
  typedef struct packed {
    logic        read;
    logic [2:0]  reg_sel;
    logic [2:0]  addr;
    logic [15:0] data;
  } dlcr_word_t;

  typedef struct packed {
    logic frame_open;
    logic sclk_rise;
    logic sclk_fall;
    logic frame_end;
  } dlcr_link_ev_t;

  typedef enum logic [1:0] {
    DLCR_IDLE  = 2'b00,
    DLCR_SHIFT = 2'b01,
    DLCR_LATCH = 2'b11
  } dlcr_state_t;
endpackage

// file: dlcr_properties.sv
// port checks for the load, clear and readout block
module dlcr_properties
  import dlcr_pkg::*;
(
  input wire logic        MCLK,
  input wire logic        RESET,
  input wire logic        SCLK,
  input wire logic        FRAME_N,
  input wire logic        LOAD_STROBE_N,
  input wire logic        CLEAR_N,
  input wire logic        SERIAL_OUT,
  input wire logic [63:0] DAC_CODE,
  input wire logic [3:0]  UPDATE_PULSE
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (RESET);
  logic [3:0] out_age;
  logic [3:0] upd_age;
  // ====
  // cycles since the last pin edge that may move each output
  always_ff @(posedge MCLK) begin
    if (RESET || $rose(SCLK) || $changed(FRAME_N)) out_age <= 4'h0;
    else if (out_age != 4'hF) out_age <= out_age + 4'h1;
  end
  always_ff @(posedge MCLK) begin
    if (RESET || $rose(FRAME_N) || $fell(LOAD_STROBE_N)) upd_age <= 4'h0;
    else if (upd_age != 4'hF) upd_age <= upd_age + 4'h1;
  end
  // ====
  // checks
  a_reset_idle: assert property ($fell(RESET) |-> DAC_CODE == 64'h0 && UPDATE_PULSE == 4'h0)
    else $error("outputs not idle after reset");
  a_pulse_single: assert property (UPDATE_PULSE != 4'h0 |=> UPDATE_PULSE == 4'h0)
    else $error("update pulse too long");
  a_pulse_cause: assert property (
    UPDATE_PULSE != 4'h0 |-> upd_age <= 4'h7)
    else $error("update pulse without cause");
  a_defer_hold: assert property (
    (LOAD_STROBE_N && CLEAR_N) [*8] |-> $stable(DAC_CODE))
    else $error("code moved while load high");
  a_clear_code: assert property (
    !CLEAR_N [*6] |-> DAC_CODE == {4{DAC_CODE[15:0]}} && DAC_CODE[14:0] == 15'h0)
    else $error("clear code wrong");
  a_clear_hold: assert property (
    !CLEAR_N [*7] |-> $stable(DAC_CODE) && UPDATE_PULSE == 4'h0)
    else $error("code moved during clear");
  a_out_edge: assert property (
    $changed(SERIAL_OUT) |-> out_age <= 4'h6)
    else $error("serial out moved off edge");
  a_out_at_fall: assert property ($fell(SCLK) |=> $stable(SERIAL_OUT) [*4])
    else $error("serial out unstable at fall");
endmodule // dlcr_properties

bind dlcr_top dlcr_properties i_props (.MCLK(MCLK), .RESET(RESET), .SCLK(SCLK),
  .FRAME_N(FRAME_N), .LOAD_STROBE_N(LOAD_STROBE_N), .CLEAR_N(CLEAR_N),
  .SERIAL_OUT(SERIAL_OUT), .DAC_CODE(DAC_CODE), .UPDATE_PULSE(UPDATE_PULSE));

// file: dlcr_regs.svh
// constants for the quad dac load, clear and readout block
// What this block does
// - With the load strobe held low, the addressed channel register updates when the frame select rises at the end of a write.
// - With the load strobe high through a frame, only the channel input register takes the new value and the output update waits.
// - A falling load strobe moves all pending input values to the outputs in the same cycle.
// - While clear is low, the channel registers are forced to zero-scale or midscale, whichever is selected.
// - The shift register contents are driven onto the serial output for daisy-chaining and readback.
// - The serial output changes on each rising edge of the serial clock while frame select is low.
// - The host frames a transfer with frame select low, and the block shifts one input bit on each falling serial-clock edge.
// - The shifted word is latched into the registers on the rising edge of frame select.
`ifndef DLCR_REGS_SVH
`define DLCR_REGS_SVH
// =====================================================================
// word format
`define DLCR_WORD_BITS   24
`define DLCR_DATA_BITS   16
`define DLCR_CHAN_COUNT  4
`define DLCR_RW_BIT      23
`define DLCR_REG_HI      21
`define DLCR_REG_LO      19
`define DLCR_ADDR_HI     18
`define DLCR_ADDR_LO     16
// =====================================================================
// register selects and addresses
`define DLCR_REG_DAC     3'h0
`define DLCR_REG_CTRL    3'h3
`define DLCR_ADDR_ALL    3'h4
`define DLCR_CTRL_CLRSEL 2
// =====================================================================
// codes and reset values
`define DLCR_ZERO_BIN    16'h0000
`define DLCR_ZERO_TWOS   16'h8000
`define DLCR_MID_BIN     16'h8000
`define DLCR_MID_TWOS    16'h0000
`define DLCR_CODE_RST    16'h0000
// pin idle levels {sclk, frame, data, load, clear}: sclk low so no false edge after reset
`define DLCR_SYNC_RST    5'h0B
`endif

// file: dlcr_top.sv
// serial frame decode, load strobe update, clear and readout for a quad dac
module dlcr_top
  import dlcr_pkg::*;
(
  input  wire logic                  MCLK,
  input  wire logic                  RESET,
  input  wire logic                  SCLK,
  input  wire logic                  FRAME_N,
  input  wire logic                  SERIAL_IN,
  input  wire logic                  LOAD_STROBE_N,
  input  wire logic                  CLEAR_N,
  input  wire logic                  BIPOLAR_CODING_SELECT,
  output logic                       SERIAL_OUT,
  output logic [4*16-1:0]            DAC_CODE,
  output logic [3:0]                 UPDATE_PULSE
);
  `include "dlcr_regs.svh"

  // =====================================================================
  // pin synchronisers
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic       sclk_q;
  logic       frame_q;
  logic       load_strobe_n_q;

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      sync_a <= `DLCR_SYNC_RST;
      sync_b <= `DLCR_SYNC_RST;
    end else begin
      sync_a <= {SCLK, FRAME_N, SERIAL_IN, LOAD_STROBE_N, CLEAR_N};
      sync_b <= sync_a;
    end
  end

  logic sclk_s;
  logic frame_s;
  logic serial_in_s;
  logic load_strobe_n_s;
  logic clear_s;
  assign sclk_s  = sync_b[4];
  assign frame_s = sync_b[3];
  assign serial_in_s  = sync_b[2];
  assign load_strobe_n_s  = sync_b[1];
  assign clear_s = sync_b[0];

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      sclk_q  <= 1'b0;
      frame_q <= 1'b1;
      load_strobe_n_q  <= 1'b1;
    end else begin
      sclk_q  <= sclk_s;
      frame_q <= frame_s;
      load_strobe_n_q  <= load_strobe_n_s;
    end
  end

  dlcr_link_ev_t ev;
  always_comb begin
    ev.frame_open = !frame_s;
    ev.sclk_rise  = sclk_s && !sclk_q;
    ev.sclk_fall  = !sclk_s && sclk_q;
    ev.frame_end  = frame_s && !frame_q;
  end

  logic load_strobe_n_fall;
  assign load_strobe_n_fall = !load_strobe_n_s && load_strobe_n_q;

  // =====================================================================
  // frame state and shift register
  dlcr_state_t state;
  logic [`DLCR_WORD_BITS-1:0] shreg;

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      state <= DLCR_IDLE;
    end else begin
      unique case (state)
        DLCR_IDLE:  if (ev.frame_open) state <= DLCR_SHIFT;
        DLCR_SHIFT: if (ev.frame_end) state <= DLCR_LATCH;
        DLCR_LATCH: state <= DLCR_IDLE;
        default:    state <= DLCR_IDLE;
      endcase
    end
  end

  // shift on falling sclk while framed; readback loads the cycle after latch of a read
  logic [15:0] rd_data;
  logic        rd_pend;
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      shreg <= '0;
    end else if (rd_pend) begin
      shreg <= {8'h00, rd_data};
    end else if (ev.frame_open && ev.sclk_fall) begin
      shreg <= {shreg[`DLCR_WORD_BITS-2:0], serial_in_s};
    end
  end

  // serial output refreshed on rising sclk only
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      SERIAL_OUT <= 1'b0;
    end else if (ev.sclk_rise && ev.frame_open) begin
      SERIAL_OUT <= shreg[`DLCR_WORD_BITS-1];
    end
  end

  dlcr_word_t word;
  // bit below the read flag carries nothing and is dropped
  assign word = dlcr_word_t'({shreg[`DLCR_RW_BIT], shreg[`DLCR_REG_HI:0]});

  logic latch;
  assign latch = (state == DLCR_LATCH);

  // =====================================================================
  // control setting: clear code choice, untouched by clear
  logic clr_mid;
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      clr_mid <= 1'b0;
    end else if (latch && !word.read && word.reg_sel == `DLCR_REG_CTRL) begin
      clr_mid <= word.data[`DLCR_CTRL_CLRSEL];
    end
  end

  // coding strap is a pin too, so it passes two flops before use
  logic [1:0] bip_sync;
  always_ff @(posedge MCLK) begin
    bip_sync <= {bip_sync[0], BIPOLAR_CODING_SELECT};
  end

  logic [15:0] clear_code;
  always_comb begin
    if (clr_mid) begin
      clear_code = bip_sync[1] ? `DLCR_MID_BIN : `DLCR_MID_TWOS;
    end else begin
      clear_code = bip_sync[1] ? `DLCR_ZERO_BIN : `DLCR_ZERO_TWOS;
    end
  end

  // =====================================================================
  // input registers, single-channel copies in the memory, readback of one channel
  logic dac_wr;
  assign dac_wr = latch && !word.read && word.reg_sel == `DLCR_REG_DAC;

  logic [3:0] hit;
  logic [3:0] pend;
  logic       mem_wr;
  logic [1:0] mem_wa;
  logic [1:0] mem_ra;
  logic [15:0] mem_q;

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      rd_pend <= 1'b0;
    end else begin
      // memory is addressed from the latched word, its data stands one cycle on
      rd_pend <= latch && word.read;
    end
  end

  // broadcast writes go straight to every channel and skip the memory, which keeps single-channel copies
  assign mem_wr = dac_wr && !word.addr[2];
  assign mem_wa = word.addr[1:0];
  assign mem_ra = word.addr[1:0];

  dlcr_chan_mem u_mem (
    .MCLK    (MCLK),
    .wr_en   (mem_wr),
    .wr_addr (mem_wa),
    .wr_data (word.data),
    .rd_addr (mem_ra),
    .rd_data (mem_q)
  );

  logic [15:0] in_reg [0:3];
  logic [15:0] out_reg [0:3];
  assign rd_data = mem_q;

  // =====================================================================
  // per channel update logic
  genvar g;
  generate
    for (g = 0; g < `DLCR_CHAN_COUNT; g++) begin : g_chan
      assign hit[g] = dac_wr && (word.addr[2] || word.addr[1:0] == 2'(g));

      always_ff @(posedge MCLK) begin
        if (RESET) begin
          in_reg[g] <= `DLCR_CODE_RST;
        end else if (hit[g]) begin
          in_reg[g] <= word.data;
        end
      end

      always_ff @(posedge MCLK) begin
        if (RESET) begin
          pend[g] <= 1'b0;
        end else if (hit[g] && load_strobe_n_s) begin
          pend[g] <= 1'b1;
        end else if (load_strobe_n_fall || !clear_s || (hit[g] && !load_strobe_n_s)) begin
          pend[g] <= 1'b0;
        end
      end

      always_ff @(posedge MCLK) begin
        if (RESET) begin
          out_reg[g] <= `DLCR_CODE_RST;
          UPDATE_PULSE[g] <= 1'b0;
        end else if (!clear_s) begin
          out_reg[g] <= clear_code;
          UPDATE_PULSE[g] <= 1'b0;
        end else if (hit[g] && !load_strobe_n_s) begin
          out_reg[g] <= word.data;
          UPDATE_PULSE[g] <= 1'b1;
        end else if (load_strobe_n_fall && pend[g]) begin
          out_reg[g] <= in_reg[g];
          UPDATE_PULSE[g] <= 1'b1;
        end else begin
          UPDATE_PULSE[g] <= 1'b0;
        end
      end

      assign DAC_CODE[g*16 +: 16] = out_reg[g];
    end
  endgenerate
endmodule // dlcr_top

// file: testbench.sv
// self-checking bench for the load, clear and readout block
`include "dlcr_regs.svh"
module testbench
  import dlcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk = 0, reset = 1, clear_n = 1, bip = 1;
  logic        load_n = 1;
  logic        sclk, frame_n, sdi, serial_out;
  logic [63:0] code;
  logic [3:0]  pulse;
  logic [23:0] rd;
  bit   [3:0]  pend;
  int          n_errors = 0, samples_checked = 0, cc;
  int          outv[4], inv[4], memv[4];
  always #4 mclk = ~mclk;
  dlcr_top i_dut (.MCLK(mclk), .RESET(reset), .SCLK(sclk), .FRAME_N(frame_n),
    .SERIAL_IN(sdi), .LOAD_STROBE_N(load_n), .CLEAR_N(clear_n),
    .BIPOLAR_CODING_SELECT(bip), .SERIAL_OUT(serial_out), .DAC_CODE(code), .UPDATE_PULSE(pulse));
  dlcr_host i_host (.SCLK(sclk), .FRAME_N(frame_n), .SERIAL_IN(sdi), .SERIAL_OUT(serial_out));
  task automatic stop_test();
    if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cmp(input logic [63:0] e, input logic [63:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk_code();
    cmp({16'(outv[3]), 16'(outv[2]), 16'(outv[1]), 16'(outv[0])}, code);
  endtask
  task automatic chk_upd(input logic [3:0] m);
    for (int i = 0; i < 20 && pulse === 4'h0; i++) tick(1);
    cmp(64'(m), 64'(pulse));
    tick(1);
    chk_code();
  endtask
  task automatic wr(input int ch, input int d);
    logic [3:0] m;
    m = 4'h0;
    i_host.xfer({2'b00, `DLCR_REG_DAC, 3'(ch), 16'(d)}, rd);
    for (int c = 0; c < 4; c++) begin
      if (ch == c || ch == `DLCR_ADDR_ALL) begin
        inv[c] = d;
        if (ch == c) memv[c] = d;
        if (clear_n && !load_n) outv[c] = d;
        if (clear_n && !load_n) m[c] = 1'b1;
        else if (clear_n) pend[c] = 1'b1;
      end
    end
    if (clear_n && !load_n) chk_upd(m);
  endtask
  initial begin
    #400us;
    n_errors++;
    stop_test();
  end
  initial begin
    void'($urandom(32'hEE61));
    tick(2);
    reset = 0;
    tick(3);
    load_n = 0;
    tick(4);
    for (int c = 0; c <= 4; c++) wr(c, $urandom);
    load_n = 1;
    for (int c = 0; c < 4; c++) wr(c, $urandom);
    tick(8);
    chk_code();
    for (int c = 0; c < 4; c++) if (pend[c]) outv[c] = inv[c];
    load_n = 0;
    chk_upd(pend);
    pend = 4'h0;
    for (int k = 0; k < 4; k++) begin
      bip = k[0];
      i_host.xfer({2'b00, `DLCR_REG_CTRL, 3'h0, 16'(k[1]) << `DLCR_CTRL_CLRSEL}, rd);
      if (k[1]) cc = k[0] ? `DLCR_MID_BIN : `DLCR_MID_TWOS;
      else cc = k[0] ? `DLCR_ZERO_BIN : `DLCR_ZERO_TWOS;
      repeat (2) begin
        wr(k, $urandom);
        clear_n = 0;
        wr(k, $urandom);
        outv = '{cc, cc, cc, cc};
        tick(8);
        chk_code();
        clear_n = 1;
        tick(4);
      end
    end
    for (int c = 0; c < 4; c++) begin
      i_host.xfer({2'b10, `DLCR_REG_DAC, 3'(c), 16'h0}, rd);
      i_host.xfer({2'b00, 3'h7, 19'h0}, rd);
      cmp(64'({8'h00, 16'(memv[c])}), 64'(rd));
    end
    stop_test();
  end
endmodule // testbench
